/* File: design/cms_sequencer.sv */
// power-up and configuration mode sequencer
// assumes pins arrive asynchronously; load done comes from clk-domain logic
`timescale 1ns/1ps
`default_nettype none
`include "cms_cfg.svh"

module cms_sequencer
  import cms_pkg::*;
#(
  parameter int POR_LONG_CYC = `CMS_POR_LONG_CYC,
  parameter int POR_SHORT_CYC = `CMS_POR_SHORT_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_delay_select,
  input wire logic weak_pull_select,
  input wire logic reconfig_request_n,
  input wire logic scan_reconfig_instr,
  input wire logic config_load_done,
  output logic config_enable,
  output logic register_reset,
  output logic user_io_oe,
  output logic weak_pull_enable,
  output cms_status_t status
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sel_sync_reg;
  logic [1:0] pull_sync_reg;
  logic [1:0] req_sync_reg;
  logic [1:0] scan_sync_reg;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sel_sync_reg <= 2'h0;
      pull_sync_reg <= 2'h0;
      req_sync_reg <= 2'h3;
      scan_sync_reg <= 2'h0;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[0], por_delay_select};
      pull_sync_reg <= {pull_sync_reg[0], weak_pull_select};
      req_sync_reg <= {req_sync_reg[0], reconfig_request_n};
      scan_sync_reg <= {scan_sync_reg[0], scan_reconfig_instr};
    end
  end

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  cms_state_t state_reg, state_next;
  logic [`CMS_CNT_W-1:0] cnt_reg, cnt_next;
  logic sel_taken_reg;
  logic sel_hold_reg;
  logic scan_prev_reg;

  // reconfig trigger: pin low or rising edge of scan instruction
  wire scan_pulse = scan_sync_reg[1] & ~scan_prev_reg;
  wire reconfig_hit = ~req_sync_reg[1] | scan_pulse;
  wire [`CMS_CNT_W-1:0] por_target = sel_hold_reg ?
    POR_SHORT_CYC[`CMS_CNT_W-1:0] - 24'h1 :
    POR_LONG_CYC[`CMS_CNT_W-1:0] - 24'h1;

  // R9 sample once
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sel_taken_reg <= 1'b0;
      sel_hold_reg <= 1'b0;
      scan_prev_reg <= 1'b0;
    end
    else
    begin
      scan_prev_reg <= scan_sync_reg[1];
      if (!sel_taken_reg && state_reg == CMS_WAIT)
      begin
        sel_taken_reg <= 1'b1;
        sel_hold_reg <= sel_sync_reg[1];
      end
    end
  end

  // next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      // synchronisers settle before the select pin is taken
      CMS_POR:
      begin
        if (cnt_reg == 24'h3)
        begin
          state_next = CMS_WAIT;
          cnt_next = 24'h0;
        end
        else
          cnt_next = cnt_reg + 24'h1;
      end
      // R1 power-on delay
      CMS_WAIT:
      begin
        if (sel_taken_reg && cnt_reg == por_target)
        begin
          state_next = CMS_LOAD;
          cnt_next = 24'h0;
        end
        else if (sel_taken_reg)
          cnt_next = cnt_reg + 24'h1;
      end
      // R2 full load needed
      CMS_LOAD:
      begin
        if (config_load_done && req_sync_reg[1])
        begin
          state_next = CMS_INIT;
          cnt_next = 24'h0;
        end
      end
      // R4 init phase
      CMS_INIT:
      begin
        if (!req_sync_reg[1])
          state_next = CMS_LOAD;
        else if (cnt_reg == `CMS_CNT_W'(`CMS_INIT_CYC - 1))
          state_next = CMS_USER;
        else
          cnt_next = cnt_reg + 24'h1;
      end
      // R6 R8 reconfig back to command mode
      CMS_USER:
      begin
        if (reconfig_hit)
          state_next = CMS_LOAD;
      end
      default:
      begin
        state_next = CMS_POR;
        cnt_next = 24'h0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= CMS_POR;
      cnt_reg <= 24'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  wire in_cmd = (state_next != CMS_USER);
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      config_enable <= 1'b0;
      register_reset <= 1'b1;
      user_io_oe <= 1'b0;
      weak_pull_enable <= 1'b0;
      status <= '{command_mode: 1'b1, user_mode: 1'b0, init_phase: 1'b0};
    end
    else
    begin
      config_enable <= (state_next == CMS_LOAD);
      // R4 registers held reset until user mode
      register_reset <= in_cmd;
      // R3 tri-state in command mode
      user_io_oe <= ~in_cmd;
      // R7 pull-ups only before and during load
      weak_pull_enable <= (state_next == CMS_POR || state_next == CMS_WAIT
        || state_next == CMS_LOAD) & ~pull_sync_reg[1];
      // R5 exclusive modes
      status.command_mode <= in_cmd;
      status.user_mode <= ~in_cmd;
      status.init_phase <= (state_next == CMS_INIT);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_modes_exclusive;
    @(posedge clk) disable iff (!reset_n)
    status.command_mode != status.user_mode;
  endproperty
  a_modes_exclusive: assert property (p_modes_exclusive) // R5
    else $error("mode flags not exclusive");

  property p_io_tristate;
    @(posedge clk) disable iff (!reset_n)
    status.command_mode |-> !user_io_oe;
  endproperty
  a_io_tristate: assert property (p_io_tristate) // R3
    else $error("i/o driven in command mode");

  // init runs its full length, then user mode follows
  sequence s_init_enter;
    $rose(status.init_phase);
  endsequence
  sequence s_init_finish;
    ##15 status.init_phase ##1 status.user_mode;
  endsequence
  property p_init_to_user;
    @(posedge clk) disable iff (!reset_n || !req_sync_reg[1])
    s_init_enter |-> s_init_finish;
  endproperty
  a_init_to_user: assert property (p_init_to_user) // R4
    else $error("init length or hand-over wrong");

  property p_user_needs_init;
    @(posedge clk) disable iff (!reset_n)
    $rose(status.user_mode) |-> $past(status.init_phase);
  endproperty
  a_user_needs_init: assert property (p_user_needs_init) // R4
    else $error("user mode without init");

  property p_load_before_init;
    @(posedge clk) disable iff (!reset_n)
    $rose(status.init_phase) |-> $past(config_enable);
  endproperty
  a_load_before_init: assert property (p_load_before_init) // R2
    else $error("init without load");

  property p_reconfig_pin;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == CMS_USER && !req_sync_reg[1]) |=> config_enable;
  endproperty
  a_reconfig_pin: assert property (p_reconfig_pin) // R6
    else $error("reconfig pin ignored");

  property p_scan_reconfig;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == CMS_USER && scan_pulse) |=> status.command_mode;
  endproperty
  a_scan_reconfig: assert property (p_scan_reconfig) // R8
    else $error("scan reconfig ignored");

  property p_pull_select;
    @(posedge clk) disable iff (!reset_n)
    (config_enable && pull_sync_reg[1] && $past(pull_sync_reg[1]))
      |-> !weak_pull_enable;
  endproperty
  a_pull_select: assert property (p_pull_select) // R7
    else $error("pull-ups on while deselected");

  property p_pull_on;
    @(posedge clk) disable iff (!reset_n)
    (config_enable && !$past(pull_sync_reg[1])) |-> weak_pull_enable;
  endproperty
  a_pull_on: assert property (p_pull_on) // R7
    else $error("pull-ups off while selected");

  property p_sel_held;
    @(posedge clk) disable iff (!reset_n)
    $past(sel_taken_reg) |-> $stable(sel_hold_reg);
  endproperty
  a_sel_held: assert property (p_sel_held) // R9
    else $error("delay select changed");

  property p_por_wait;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == CMS_WAIT && !sel_taken_reg) |=> state_reg == CMS_WAIT;
  endproperty
  a_por_wait: assert property (p_por_wait) // R1
    else $error("delay skipped");

endmodule
`default_nettype wire

/* File: shared/cms_cfg.svh */
// constants for the configuration mode sequencer
// assumes a 125 MHz clock and pins passed through two-flop synchronisers
//
// Contract
// R1 - power-on delay is 100 ms with the delay-select pin low, 12 ms high.
// R2 - every power-up needs a full configuration load before user mode.
// R3 - user i/o stays high-impedance from power-up until configured.
// R4 - after loading, an init phase resets registers, releases i/o, runs.
// R5 - the device is in exactly one of command mode or user mode.
// R6 - a low reconfig request in user mode forces a fresh load and init.
// R7 - weak pull-ups are off when pull select is high, on when low; the code turns them on only before and during load.
// R8 - the scan reconfig instruction acts like a pulse on the reconfig pin.
// R9 - the delay-select pin is sampled once and held until power cycle.
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

`define CMS_CLK_MHZ 125
`define CMS_POR_LONG_MS 100
`define CMS_POR_SHORT_MS 12
`define CMS_POR_LONG_CYC (`CMS_POR_LONG_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_POR_SHORT_CYC (`CMS_POR_SHORT_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_INIT_CYC 16
`define CMS_CNT_W 24

`endif

/* File: shared/cms_pkg.sv */
// types for the configuration mode sequencer
// assumes the cfg header is included by users of timing values
package cms_pkg;

  typedef enum logic [4:0] {
    CMS_POR = 5'b00001,
    CMS_WAIT = 5'b00010,
    CMS_LOAD = 5'b00100,
    CMS_INIT = 5'b01000,
    CMS_USER = 5'b10000
  } cms_state_t;

  // status seen by the surrounding device
  typedef struct packed {
    logic command_mode;
    logic user_mode;
    logic init_phase;
  } cms_status_t;

endpackage

/* File: test/cms_cfg_source.sv */
// configuration source model on the far side of the sequencer
// assumes the bench can stall it to hold a load unfinished
`timescale 1ns/1ps
`default_nettype none
module cms_cfg_source
(
  input wire logic clk,
  input wire logic config_enable,
  input wire logic stall,
  output logic config_load_done
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk)
  begin
    cnt_reg <= config_enable ? cnt_reg + 4'h1 : 4'h0;
    config_load_done <= config_enable && !stall && cnt_reg == 4'h7;
  end
endmodule
`default_nettype wire

/* File: test/test_cms_sequencer.sv */
// bench for the configuration mode sequencer
// assumes short power-on counts of 20 and 8 cycles
`timescale 1ns/1ps
`default_nettype none
module test_cms_sequencer
  import cms_pkg::*;
();
  logic clk = 0, reset_n = 0, sel = 0, pull = 0;
  logic req_n = 1, scan = 0, stall = 0;
  logic done, ce, rr, oe, wpe;
  cms_status_t st;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #4 clk = !clk;
  cms_sequencer #(.POR_LONG_CYC(20), .POR_SHORT_CYC(8)) cms_sequencer_inst
  (.clk(clk), .reset_n(reset_n), .por_delay_select(sel),
   .weak_pull_select(pull), .reconfig_request_n(req_n),
   .scan_reconfig_instr(scan), .config_load_done(done),
   .config_enable(ce), .register_reset(rr), .user_io_oe(oe),
   .weak_pull_enable(wpe), .status(st));
  cms_cfg_source cms_cfg_source_inst
  (.clk(clk), .config_enable(ce), .stall(stall),
   .config_load_done(done));
  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic check_n(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("FAIL %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset, then count cycles until loading opens
  task automatic power_up(input logic s, input logic p, output int n);
    reset_n = 0;
    sel = s;
    pull = p;
    tick(16);
    reset_n = 1;
    n = 0;
    while (ce !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
      if (n == 10)
        sel = !s; // late change ignored
      check(oe, 1'b0); // io off in power-up
    end
    check({wpe, rr, oe}, {!p, 2'b10}); // pull choice
    check(st, 3'b100); // command only
  endtask
  // follow init into user mode
  task automatic to_user;
    int k;
    k = 0;
    while (st.init_phase !== 1'b1 && k < 100)
    begin
      tick(1);
      k++;
    end
    check({wpe, rr, oe}, 3'b010); // regs reset, io off
    check(st, 3'b101); // init in command
    k = 0;
    while (st.user_mode !== 1'b1 && k < 100)
    begin
      tick(1);
      k++;
    end
    check_n(k, 16); // init length
    check({wpe, rr, oe}, 3'b001); // io released
    check(st, 3'b010); // user only
  endtask
  task automatic t_por;
    int a, b;
    stall = 1;
    power_up(0, 0, a);
    tick(30);
    check({ce, oe, st.user_mode}, 3'b100); // waits for load
    stall = 0;
    to_user;
    power_up(1, 1, b);
    to_user;
    check_n(a - b, 20 - 8); // long minus short
  endtask
  task automatic t_reconfig(input logic use_pin);
    int k;
    if (use_pin)
      req_n = 0;
    else
      scan = 1;
    k = 0;
    while (ce !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    check_n(k <= 4, 1); // quick return
    check({wpe, rr, oe}, {!pull, 2'b10}); // io off again
    check(st, 3'b100); // command only
    req_n = 1;
    scan = 0;
    to_user;
  endtask
  // pin held low through a load, then pulled low again in init
  task automatic t_hold_abort;
    int k;
    req_n = 0;
    tick(20);
    check({ce, st.init_phase, oe}, 3'b100); // done ignored while low
    req_n = 1;
    k = 0;
    while (st.init_phase !== 1'b1 && k < 40)
    begin
      tick(1);
      k++;
    end
    tick(4);
    req_n = 0;
    k = 0;
    while (ce !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    check_n(k, 3); // init abandoned
    check(st, 3'b100); // back in load
    req_n = 1;
    to_user;
  endtask
  // cycle ceiling against a hang
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  initial
  begin
    t_por;
    t_reconfig(1); // pin request
    t_reconfig(0); // scan request
    t_hold_abort; // hold and abort
    print_verdict;
  end
endmodule
`default_nettype wire
